// >>> shared/msc_consts.svh
`ifndef MSC_CONSTS_SVH
`define MSC_CONSTS_SVH

// register byte offsets
`define MSC_OFF_CFG0     6'h00
`define MSC_OFF_CFG1     6'h04
`define MSC_OFF_EN0      6'h08
`define MSC_OFF_EN1      6'h0c
`define MSC_OFF_RATE0    6'h10
`define MSC_OFF_RATE1    6'h14
`define MSC_OFF_DEV0     6'h18
`define MSC_OFF_DEV1     6'h1c
`define MSC_OFF_STATUS   6'h20
`define MSC_OFF_TRIGCTL  6'h24

// configuration fields
`define MSC_CFG_SHAPE_LSB 0
`define MSC_CFG_SRC_LSB   4

// modulation type bit positions in the enable register
`define MSC_MOD_AM       0
`define MSC_MOD_FM       1
`define MSC_MOD_PM       2
`define MSC_MOD_PWM      3
`define MSC_MOD_PSK      4
`define MSC_MOD_FSK      5
`define MSC_MOD_COUNT    6
`define MSC_EN_SWEEP     8
`define MSC_EN_BURST     9
`define MSC_EN_PULSE     12

// status fields
`define MSC_ST_REJECT    0
`define MSC_ST_KEY0      1
`define MSC_ST_KEY1      2
`define MSC_ST_TRIG      3

// reset values
`define MSC_CFG_RESET    32'h0000_0000
`define MSC_EN_RESET     32'h0000_0000
`define MSC_RATE_RESET   32'h03e8_03e8
`define MSC_DEV_RESET    32'h0000_0000

// external level full scale is 2 to this power
`define MSC_LEVEL_SHIFT  11

// bus answers
`define MSC_RESP_OKAY    2'b00
`define MSC_RESP_SLVERR  2'b10
`define MSC_RESP_DECERR  2'b11

`endif

// >>> shared/msc_pkg.sv
package msc_pkg;

  typedef enum logic [2:0] {
    shape_sine,
    shape_a,
    shape_rising_ramp,
    shape_falling_ramp,
    shape_b,
    shape_noise,
    shape_pseudo_random_bits,
    shape_arbitrary
  } msc_shape_t;

  typedef enum logic [1:0] {
    source_internal,
    source_external,
    source_channel_one,
    source_channel_two
  } msc_source_t;

  typedef struct packed {
    logic [5:0]         mod_en;
    logic               sweep_en;
    logic               burst_en;
    logic               shape_active;
    msc_shape_t         shape;
    msc_source_t        source;
    logic               key_alt;
    logic signed [15:0] ext_offset;
  } msc_chan_out_t;

endpackage : msc_pkg

// >>> hw/msc_ext_scale.sv
`timescale 1ns/10ps
`include "msc_consts.svh"

module msc_ext_scale
  import msc_pkg::*;
#(
  parameter int LEVEL_W = 12,
  parameter int DEV_W   = 16
) (
  input  wire logic                      CLK_SYS,
  input  wire logic                      RESET,
  input  wire logic                      active,
  input  wire logic signed [LEVEL_W-1:0] level,
  input  wire logic        [DEV_W-1:0]   deviation,
  output logic signed      [DEV_W-1:0]   offset
);

  initial begin
    if (LEVEL_W != `MSC_LEVEL_SHIFT + 1) $error("msc_ext_scale: LEVEL_W must match full scale");
    if (DEV_W < 2) $error("msc_ext_scale: DEV_W too small");
  end

  logic signed [LEVEL_W+DEV_W:0] product;

  // full negative level gives minus the whole deviation, full positive 2047/2048 of it
  assign product = level * $signed({1'b0, deviation});

  // registered offset, zero unless the external source drives this channel
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      offset <= '0;
    end else if (active) begin
      offset <= product[`MSC_LEVEL_SHIFT +: DEV_W];
    end else begin
      offset <= '0;
    end
  end

endmodule : msc_ext_scale

// >>> hw/msc_key_gen.sv
`timescale 1ns/10ps
`include "msc_consts.svh"

module msc_key_gen
  import msc_pkg::*;
#(
  parameter int RATE_W = 16
) (
  input  wire logic              CLK_SYS,
  input  wire logic              RESET,
  input  wire logic              run,
  input  wire logic              use_ext,
  input  wire logic              trig_level,
  input  wire logic [RATE_W-1:0] half_period,
  output logic                   key_alt
);

  initial begin
    if (RATE_W < 2) $error("msc_key_gen: RATE_W too small");
  end

  logic [RATE_W-1:0] count;
  logic              tick;
  logic              int_key;

  assign tick = (count == '0);

  // divider giving a one-cycle tick every half_period cycles
  always_ff @(posedge CLK_SYS) begin
    if (RESET || !run) begin
      count <= '0;
    end else if (tick) begin
      count <= (half_period == '0) ? '0 : half_period - 1'b1;
    end else begin
      count <= count - 1'b1;
    end
  end

  // internal key alternates carrier and alternate on each tick
  always_ff @(posedge CLK_SYS) begin
    if (RESET || !run) begin
      int_key <= 1'b0;
    end else if (tick) begin
      int_key <= ~int_key;
    end
  end

  // external key follows the trigger level only, no edge polarity
  always_ff @(posedge CLK_SYS) begin
    if (RESET || !run) begin
      key_alt <= 1'b0;
    end else if (use_ext) begin
      key_alt <= trig_level;
    end else begin
      key_alt <= int_key;
    end
  end

endmodule : msc_key_gen

// >>> hw/msc_top.sv
`timescale 1ns/10ps
`include "msc_consts.svh"

module msc_top
  import msc_pkg::*;
#(
  parameter int ADDR_W  = 6,
  parameter int LEVEL_W = 12
) (
  input  wire logic                      CLK_SYS,
  input  wire logic                      RESET,
  input  wire logic                      S_AXI_AWVALID,
  output logic                           S_AXI_AWREADY,
  input  wire logic [ADDR_W-1:0]         S_AXI_AWADDR,
  input  wire logic [2:0]                S_AXI_AWPROT,
  input  wire logic                      S_AXI_WVALID,
  output logic                           S_AXI_WREADY,
  input  wire logic [31:0]               S_AXI_WDATA,
  input  wire logic [3:0]                S_AXI_WSTRB,
  output logic                           S_AXI_BVALID,
  input  wire logic                      S_AXI_BREADY,
  output logic [1:0]                     S_AXI_BRESP,
  input  wire logic                      S_AXI_ARVALID,
  output logic                           S_AXI_ARREADY,
  input  wire logic [ADDR_W-1:0]         S_AXI_ARADDR,
  input  wire logic [2:0]                S_AXI_ARPROT,
  output logic                           S_AXI_RVALID,
  input  wire logic                      S_AXI_RREADY,
  output logic [31:0]                    S_AXI_RDATA,
  output logic [1:0]                     S_AXI_RRESP,
  input  wire logic                      TRIG_IN,
  input  wire logic signed [LEVEL_W-1:0] EXT_LEVEL,
  output logic                           TRIG_EDGE_POLARITY,
  output msc_chan_out_t [1:0]            CHAN_OUT
);

  initial begin
    if (ADDR_W < 6) $error("msc_top: ADDR_W must reach the register map");
    if (LEVEL_W != `MSC_LEVEL_SHIFT + 1) $error("msc_top: LEVEL_W must match full scale");
  end

  // merge a write into a word under the byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = data[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // source field of one modulation type
  function automatic msc_source_t src_of(input logic [31:0] cfg, input int i);
    return msc_source_t'(cfg[`MSC_CFG_SRC_LSB + 2*i +: 2]);
  endfunction : src_of

  // source configuration check for channel ch
  function automatic logic cfg_ok(input logic ch, input logic [31:0] cfg);
    logic        ok;
    msc_source_t s;
    ok = 1'b1;
    for (int i = 0; i < `MSC_MOD_COUNT; i++) begin
      s = src_of(cfg, i);
      if ((i == `MSC_MOD_PSK || i == `MSC_MOD_FSK) &&
          (s == source_channel_one || s == source_channel_two)) begin
        ok = 1'b0;
      end
      if ((!ch && s == source_channel_one) || (ch && s == source_channel_two)) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : cfg_ok

  // enable word check
  function automatic logic en_ok(input logic [31:0] en);
    logic [2:0] n;
    n = '0;
    for (int i = 0; i < `MSC_MOD_COUNT; i++) begin
      n = n + {2'b00, en[i]};
    end
    return (n <= 3'd1) &&
           !(en[`MSC_MOD_PWM] && !en[`MSC_EN_PULSE]);
  endfunction : en_ok

  // source of the enabled type, internal when none is enabled
  function automatic msc_source_t active_src(input logic [31:0] cfg, input logic [31:0] en);
    msc_source_t s;
    s = source_internal;
    for (int i = 0; i < `MSC_MOD_COUNT; i++) begin
      if (en[i]) begin
        s = src_of(cfg, i);
      end
    end
    return s;
  endfunction : active_src

  logic [31:0]       cfg_reg  [2];
  logic [31:0]       en_reg   [2];
  logic [31:0]       rate_reg [2];
  logic [31:0]       dev_reg  [2];
  logic              reject;
  logic              edge_pol;
  logic [2:0]        trig_sync;
  logic              trig_level;
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              do_write;
  logic [5:0]        wr_off;
  logic              wr_ch;
  logic [31:0]       cfg_new;
  logic [31:0]       en_new;
  logic              wr_map;
  logic              wr_bad;
  logic              key_alt [2];
  logic [5:0]        rd_off;
  logic              rd_ch;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;

  // write address and data are taken in either order and held
  assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_held && !S_AXI_BVALID;
  assign do_write      = aw_held && w_held && !S_AXI_BVALID;
  assign wr_off        = {aw_addr[5:2], 2'b00};
  assign wr_ch         = aw_addr[2];
  assign cfg_new       = merge(cfg_reg[wr_ch], w_data, w_strb);
  assign en_new        = merge(en_reg[wr_ch], w_data, w_strb);

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held <= 1'b1;
      aw_addr <= S_AXI_AWADDR;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held <= 1'b1;
      w_data <= S_AXI_WDATA;
      w_strb <= S_AXI_WSTRB;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // decode the held write and decide whether it is refused
  always_comb begin
    wr_map = 1'b1;
    wr_bad = 1'b0;
    if ((aw_addr >> 6) != '0) begin
      wr_map = 1'b0;
    end else if (wr_off == `MSC_OFF_CFG0 || wr_off == `MSC_OFF_CFG1) begin
      wr_bad = !cfg_ok(wr_ch, cfg_new);
    end else if (wr_off == `MSC_OFF_EN0 || wr_off == `MSC_OFF_EN1) begin
      wr_bad = !en_ok(en_new);
    end else if (wr_off == `MSC_OFF_RATE0 || wr_off == `MSC_OFF_RATE1) begin
      wr_bad = 1'b0;
    end else if (wr_off == `MSC_OFF_DEV0 || wr_off == `MSC_OFF_DEV1) begin
      wr_bad = 1'b0;
    end else if (wr_off == `MSC_OFF_STATUS || wr_off == `MSC_OFF_TRIGCTL) begin
      wr_bad = 1'b0;
    end else begin
      wr_map = 1'b0;
    end
  end

  // write response, error for refused or unmapped writes
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `MSC_RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      if (!wr_map) begin
        S_AXI_BRESP <= `MSC_RESP_DECERR;
      end else if (wr_bad) begin
        S_AXI_BRESP <= `MSC_RESP_SLVERR;
      end else begin
        S_AXI_BRESP <= `MSC_RESP_OKAY;
      end
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // source and shape per channel, whole write dropped when refused
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      cfg_reg[0] <= `MSC_CFG_RESET;
      cfg_reg[1] <= `MSC_CFG_RESET;
    end else if (do_write && wr_map && !wr_bad &&
                 (wr_off == `MSC_OFF_CFG0 || wr_off == `MSC_OFF_CFG1)) begin
      cfg_reg[wr_ch] <= cfg_new & 32'h0000_fff7;
    end
  end

  // enables, sweep and burst are cleared by any modulation enable
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      en_reg[0] <= `MSC_EN_RESET;
      en_reg[1] <= `MSC_EN_RESET;
    end else if (do_write && wr_map && !wr_bad &&
                 (wr_off == `MSC_OFF_EN0 || wr_off == `MSC_OFF_EN1)) begin
      en_reg[wr_ch] <= en_new & 32'h0000_133f;
      if (|en_new[`MSC_MOD_COUNT-1:0]) begin
        en_reg[wr_ch][`MSC_EN_SWEEP] <= 1'b0;
        en_reg[wr_ch][`MSC_EN_BURST] <= 1'b0;
      end
    end
  end

  // keying rates and deviations per channel
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      rate_reg[0] <= `MSC_RATE_RESET;
      rate_reg[1] <= `MSC_RATE_RESET;
      dev_reg[0]  <= `MSC_DEV_RESET;
      dev_reg[1]  <= `MSC_DEV_RESET;
    end else if (do_write && wr_map) begin
      if (wr_off == `MSC_OFF_RATE0 || wr_off == `MSC_OFF_RATE1) begin
        rate_reg[wr_ch] <= merge(rate_reg[wr_ch], w_data, w_strb);
      end else if (wr_off == `MSC_OFF_DEV0 || wr_off == `MSC_OFF_DEV1) begin
        dev_reg[wr_ch] <= merge(dev_reg[wr_ch], w_data, w_strb) & 32'h0000_ffff;
      end
    end
  end

  // sticky refusal flag, a new refusal wins over a clear
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      reject <= 1'b0;
    end else if (do_write && wr_map && wr_bad) begin
      reject <= 1'b1;
    end else if (do_write && wr_off == `MSC_OFF_STATUS && w_strb[0] &&
                 w_data[`MSC_ST_REJECT]) begin
      reject <= 1'b0;
    end
  end

  // trigger edge polarity is only stored, read back and driven on TRIG_EDGE_POLARITY, the trigger logic ignores it
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      edge_pol <= 1'b0;
    end else if (do_write && wr_off == `MSC_OFF_TRIGCTL && w_strb[0]) begin
      edge_pol <= w_data[0];
    end
  end

  assign TRIG_EDGE_POLARITY = edge_pol;

  // trigger pin synchroniser, level changes once stages two and three agree
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      trig_sync  <= '0;
      trig_level <= 1'b0;
    end else begin
      trig_sync <= {trig_sync[1:0], TRIG_IN};
      if (trig_sync[1] == trig_sync[2]) begin
        trig_level <= trig_sync[2];
      end
    end
  end

  // read decode
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign rd_off        = {S_AXI_ARADDR[5:2], 2'b00};
  assign rd_ch         = S_AXI_ARADDR[2];

  always_comb begin
    next_rdata = '0;
    next_rresp = `MSC_RESP_OKAY;
    if ((S_AXI_ARADDR >> 6) != '0) begin
      next_rresp = `MSC_RESP_DECERR;
    end else if (rd_off == `MSC_OFF_CFG0 || rd_off == `MSC_OFF_CFG1) begin
      next_rdata = cfg_reg[rd_ch];
    end else if (rd_off == `MSC_OFF_EN0 || rd_off == `MSC_OFF_EN1) begin
      next_rdata = en_reg[rd_ch];
    end else if (rd_off == `MSC_OFF_RATE0 || rd_off == `MSC_OFF_RATE1) begin
      next_rdata = rate_reg[rd_ch];
    end else if (rd_off == `MSC_OFF_DEV0 || rd_off == `MSC_OFF_DEV1) begin
      next_rdata = dev_reg[rd_ch];
    end else if (rd_off == `MSC_OFF_STATUS) begin
      next_rdata[`MSC_ST_REJECT] = reject;
      next_rdata[`MSC_ST_KEY0]   = key_alt[0];
      next_rdata[`MSC_ST_KEY1]   = key_alt[1];
      next_rdata[`MSC_ST_TRIG]   = trig_level;
    end else if (rd_off == `MSC_OFF_TRIGCTL) begin
      next_rdata[0] = edge_pol;
    end else begin
      next_rresp = `MSC_RESP_DECERR;
    end
  end

  // read answer registered on the same edge that takes the address
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= '0;
      S_AXI_RRESP  <= `MSC_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= next_rdata;
      S_AXI_RRESP  <= next_rresp;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // per channel datapath
  for (genvar c = 0; c < 2; c++) begin : g_chan
    msc_source_t       src;
    logic              keying;
    logic              key_ext;
    logic [15:0]       half;
    logic signed [15:0] offset;

    assign src     = active_src(cfg_reg[c], en_reg[c]);
    assign keying  = en_reg[c][`MSC_MOD_PSK] | en_reg[c][`MSC_MOD_FSK];
    assign key_ext = (src == source_external);
    // phase keying rate low half, frequency keying rate high half
    assign half    = en_reg[c][`MSC_MOD_FSK] ? rate_reg[c][31:16] : rate_reg[c][15:0];

    msc_key_gen #(
      .RATE_W (16)
    ) u_key (
      .CLK_SYS     (CLK_SYS),
      .RESET       (RESET),
      .run         (keying),
      .use_ext     (key_ext),
      .trig_level  (trig_level),
      .half_period (half),
      .key_alt     (key_alt[c])
    );

    msc_ext_scale #(
      .LEVEL_W (LEVEL_W),
      .DEV_W   (16)
    ) u_scale (
      .CLK_SYS   (CLK_SYS),
      .RESET     (RESET),
      .active    (key_ext && !keying && |en_reg[c][3:0]),
      .level     (EXT_LEVEL),
      .deviation (dev_reg[c][15:0]),
      .offset    (offset)
    );

    // channel outputs
    assign CHAN_OUT[c].mod_en       = en_reg[c][`MSC_MOD_COUNT-1:0];
    assign CHAN_OUT[c].sweep_en     = en_reg[c][`MSC_EN_SWEEP];
    assign CHAN_OUT[c].burst_en     = en_reg[c][`MSC_EN_BURST];
    assign CHAN_OUT[c].shape_active = (src == source_internal) && !keying;
    assign CHAN_OUT[c].shape        = msc_shape_t'(cfg_reg[c][`MSC_CFG_SHAPE_LSB +: 3]);
    assign CHAN_OUT[c].source       = src;
    assign CHAN_OUT[c].key_alt      = key_alt[c];
    assign CHAN_OUT[c].ext_offset   = offset;
  end

endmodule : msc_top

// >>> verification/msc_monitor.sv
`timescale 1ns/10ps
module msc_monitor
  import msc_pkg::*;
(
  input wire logic                CLK_SYS,
  input wire logic                RESET,
  input wire logic                TRIG_IN,
  input wire msc_chan_out_t [1:0] CHAN_OUT
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // channel zero phase keyed from the pin
  logic ext_key;
  assign ext_key = CHAN_OUT[0].mod_en[4] && CHAN_OUT[0].source == source_external;
  // enable and source relations
  AST_ONE_TYPE: assert property (
    $onehot0(CHAN_OUT[0].mod_en) && $onehot0(CHAN_OUT[1].mod_en)) else $error("two types enabled");
  AST_NO_SWEEP: assert property (
    |CHAN_OUT[0].mod_en |-> !CHAN_OUT[0].sweep_en && !CHAN_OUT[0].burst_en) else $error("sweep with mod");
  AST_SELF_SRC: assert property (
    CHAN_OUT[0].source != source_channel_one && CHAN_OUT[1].source != source_channel_two) else $error("self source");
  AST_KEY_SRC: assert property (
    CHAN_OUT[0].mod_en[5:4] != 2'b00 |-> CHAN_OUT[0].source inside {source_internal, source_external})
    else $error("keying from a channel");
  AST_SHAPE_USE: assert property (
    CHAN_OUT[0].shape_active |-> CHAN_OUT[0].source == source_internal && CHAN_OUT[0].mod_en[5:4] == 2'b00)
    else $error("shape active wrongly");
  // keying follows the pin level
  AST_EXT_HIGH: assert property (
    (ext_key && TRIG_IN) [*8] |-> CHAN_OUT[0].key_alt) else $error("key low with pin high");
  AST_EXT_LOW: assert property (
    (ext_key && !TRIG_IN) [*8] |-> !CHAN_OUT[0].key_alt) else $error("key high with pin low");
  // offset only for external level types
  AST_OFF_IDLE: assert property (
    (CHAN_OUT[0].source != source_external || CHAN_OUT[0].mod_en[3:0] == 4'h0) [*2]
    |-> CHAN_OUT[0].ext_offset == 16'sh0000) else $error("offset without external type");
  AST_RESET_VAL: assert property (
    $fell(RESET) |-> CHAN_OUT[0].mod_en == 6'h00 && CHAN_OUT[0].shape == shape_sine
    && CHAN_OUT[1].source == source_internal) else $error("bad state after reset");
endmodule : msc_monitor

bind msc_top msc_monitor u_mon (.CLK_SYS(CLK_SYS), .RESET(RESET), .TRIG_IN(TRIG_IN), .CHAN_OUT(CHAN_OUT));

// >>> verification/msc_ext_src.sv
`timescale 1ns/10ps
module msc_ext_src
  import msc_pkg::*;
#(
  parameter int MIN_HOLD = 5
) (
  input  wire logic               CLK_SYS,
  input  wire logic               RESET,
  input  wire logic               trig_req,
  input  wire logic signed [11:0] level_req,
  output logic                    trig_out,
  output logic signed [11:0]      level_out
);
  logic [7:0] hold;
  // pin level moves only after MIN_HOLD cycles since its last change
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      trig_out <= 1'b0;
      hold     <= 8'h00;
    end else if (trig_req != trig_out && hold >= MIN_HOLD) begin
      trig_out <= trig_req;
      hold     <= 8'h00;
    end else if (hold != 8'hff) begin
      hold <= hold + 8'h01;
    end
  end
  // analog level one cycle late
  always_ff @(posedge CLK_SYS) begin
    level_out <= level_req;
  end
endmodule : msc_ext_src

// >>> verification/tb.sv
`timescale 1ns/10ps
module tb
  import msc_pkg::*;
  ;
  typedef struct packed {logic [5:0] a; logic [31:0] wd; logic [1:0] wr; logic [31:0] rd; logic [1:0] rr;} msc_row_t;
  logic reset = 1'b1, clk_sys = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0, trig_req = 1'b0;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic signed [11:0] level_req = 12'sh000;
  logic awready, wready, bvalid, arready, rvalid, trig_in, trig_pol;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic signed [11:0] ext_level;
  msc_chan_out_t [1:0] chan_out;
  int failures, num_checks, cycles;
  msc_row_t rows [14] = '{'{6'h00, 32'h1b, 2'h0, 32'h13, 2'h0}, '{6'h00, 32'h23, 2'h2, 32'h13, 2'h0},
    '{6'h04, 32'h34, 2'h2, 32'h0, 2'h0}, '{6'h00, 32'hc013, 2'h2, 32'h13, 2'h0},
    '{6'h00, 32'h313, 2'h0, 32'h313, 2'h0}, '{6'h04, 32'h206, 2'h0, 32'h206, 2'h0},
    '{6'h08, 32'h300, 2'h0, 32'h300, 2'h0}, '{6'h08, 32'h301, 2'h0, 32'h1, 2'h0},
    '{6'h08, 32'h3, 2'h2, 32'h1, 2'h0}, '{6'h08, 32'h8, 2'h2, 32'h1, 2'h0},
    '{6'h08, 32'h1008, 2'h0, 32'h1008, 2'h0}, '{6'h20, 32'h0, 2'h0, 32'h1, 2'h0},
    '{6'h28, 32'h5, 2'h3, 32'h0, 2'h3}, '{6'h20, 32'h1, 2'h0, 32'h0, 2'h0}};

  msc_top dut (.CLK_SYS(clk_sys), .RESET(reset), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .TRIG_IN(trig_in),
    .EXT_LEVEL(ext_level), .TRIG_EDGE_POLARITY(trig_pol), .CHAN_OUT(chan_out));
  msc_ext_src u_src (.CLK_SYS(clk_sys), .RESET(reset), .trig_req(trig_req), .level_req(level_req),
    .trig_out(trig_in), .level_out(ext_level));

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  // cut a hang short
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  // write with address and data offered together
  task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_ok, w_ok, aw_hit, w_hit;
    logic [1:0] resp;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge clk_sys);
      aw_hit = awready && !aw_ok;
      w_hit = wready && !w_ok;
      @(posedge clk_sys);
      if (aw_hit) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (w_hit) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    aw_hit = 1'b0;
    while (!aw_hit) begin
      @(negedge clk_sys);
      aw_hit = bvalid;
      resp = bresp;
      @(posedge clk_sys);
    end
    bready <= 1'b0;
    chk(resp, r);
  endtask : axi_wr

  task automatic axi_rd(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
    logic hit;
    logic [31:0] got;
    logic [1:0] resp;
    hit = 1'b0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!hit) begin
      @(negedge clk_sys);
      hit = arready;
      @(posedge clk_sys);
    end
    arvalid <= 1'b0;
    hit = 1'b0;
    while (!hit) begin
      @(negedge clk_sys);
      hit = rvalid;
      got = rdata;
      resp = rresp;
      @(posedge clk_sys);
    end
    rready <= 1'b0;
    chk(got, d);
    chk(resp, r);
  endtask : axi_rd

  task automatic do_reset(input int n);
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (n) @(posedge clk_sys);
    reset <= 1'b0;
  endtask : do_reset

  // main sequence
  initial begin
    int n;
    logic kv;
    do_reset(11);
    for (int i = 0; i < 4; i++) axi_rd(6'(i * 4), 32'h0, 2'h0);
    axi_rd(6'h10, 32'h03e8_03e8, 2'h0);
    foreach (rows[i]) begin
      axi_wr(rows[i].a, rows[i].wd, rows[i].wr);
      axi_rd(rows[i].a, rows[i].rd, rows[i].rr);
    end
    // external level scaled by the deviation, parameters before enable
    axi_wr(6'h18, 32'h0400, 2'h0);
    for (int t = 0; t < 4; t++) begin
      axi_wr(6'h00, 32'h1 << (4 + 2 * t), 2'h0);
      axi_wr(6'h08, (32'h1 << t) | 32'h1000, 2'h0);
      for (int j = 0; j < 2; j++) begin
        @(posedge clk_sys);
        level_req <= j ? 12'sh800 : 12'sd2047;
        repeat (4) @(negedge clk_sys);
        chk(chan_out[0].ext_offset, j ? -32'sd1024 : 32'sd1023);
      end
      chk(chan_out[0].source, source_external);
    end
    // internal source ignores the level
    axi_wr(6'h00, 32'h5, 2'h0);
    axi_wr(6'h08, 32'h1, 2'h0);
    repeat (3) @(negedge clk_sys);
    chk(chan_out[0].ext_offset, 32'h0);
    chk(chan_out[0].shape_active, 32'h1);
    chk(chan_out[0].shape, shape_noise);
    // pin keying by level whatever the edge polarity
    axi_wr(6'h00, 32'h5000, 2'h0);
    for (int k = 0; k < 2; k++) begin
      axi_wr(6'h08, 32'h10 << k, 2'h0);
      for (int j = 0; j < 4; j++) begin
        axi_wr(6'h24, j >> 1, 2'h0);
        @(posedge clk_sys);
        trig_req <= !j[0];
        repeat (12) @(negedge clk_sys);
        chk(chan_out[0].key_alt, !j[0]);
        chk(trig_pol, j >> 1);
        axi_rd(6'h20, {28'h0, !j[0], 1'b0, !j[0], 1'b0}, 2'h0);
      end
    end
    // internal keying half periods of three and five cycles
    axi_wr(6'h10, 32'h0005_0003, 2'h0);
    axi_wr(6'h00, 32'h0, 2'h0);
    for (int k = 0; k < 2; k++) begin
      axi_wr(6'h08, 32'h10 << k, 2'h0);
      @(negedge clk_sys);
      kv = chan_out[0].key_alt;
      while (chan_out[0].key_alt === kv) @(negedge clk_sys);
      kv = chan_out[0].key_alt;
      n = 0;
      while (chan_out[0].key_alt === kv) begin
        @(negedge clk_sys);
        n++;
      end
      chk(n, k ? 5 : 3);
      chk(chan_out[1].mod_en, 32'h0);
    end
    // second reset in mid-run
    do_reset(2);
    axi_rd(6'h08, 32'h0, 2'h0);
    axi_rd(6'h00, 32'h0, 2'h0);
    results();
  end
endmodule : tb
